// file: hw/rsti_defs.svh
// Constants for the reset-state and test identification block.
// Assumes inclusion by bare name from the package and the main module.
`ifndef RSTI_DEFS_SVH
`define RSTI_DEFS_SVH

// ----------------------------------------
// Identification register fields
// ----------------------------------------
`define RSTI_ID_W         32
`define RSTI_VER_MSB      31
`define RSTI_VER_LSB      28
`define RSTI_PART_MSB     27
`define RSTI_PART_LSB     12
`define RSTI_MFR_MSB      11
`define RSTI_MFR_LSB      1
`define RSTI_ID_LSB_VAL   1'b1
// Arbitrary neutral values, not any real part's codes
`define RSTI_VERSION      4'h1
`define RSTI_PART_NUM     16'h1234
`define RSTI_MFR_CODE     11'h2aa
`define RSTI_SIG_BASE     28'h0000abc
`define RSTI_STEPPING     4'h2

// ----------------------------------------
// Register widths and reset values
// ----------------------------------------
`define RSTI_MSR_W        64
`define RSTI_MSR_RST      64'h0000_0000_0000_0000
`define RSTI_GPR_W        32

// ----------------------------------------
// Scan instructions
// ----------------------------------------
`define RSTI_IR_W         4
`define RSTI_IR_IDCODE    4'h1
`define RSTI_IR_BYPASS    4'hf
`define RSTI_IR_CAPTURE   4'h1

`endif

// file: hw/rsti_pkg.sv
// Types for the reset-state and test identification block.
// Assumes the constants header sits beside it.
`include "rsti_defs.svh"
package rsti_pkg;
  // Standard test access port controller states
  typedef enum logic [3:0] {
    RSTI_TLR, RSTI_RTI, RSTI_SEL_DR, RSTI_CAP_DR, RSTI_SH_DR, RSTI_EX1_DR,
    RSTI_PA_DR, RSTI_EX2_DR, RSTI_UPD_DR, RSTI_SEL_IR, RSTI_CAP_IR,
    RSTI_SH_IR, RSTI_EX1_IR, RSTI_PA_IR, RSTI_EX2_IR, RSTI_UPD_IR
  } rsti_tap_t;
endpackage

// file: hw/rsti_sync.sv
// Three-stage synchroniser for pins from outside the ref_clk domain.
// Assumes an asynchronous input; output changes when stages two and three agree.
module rsti_sync (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic din,
  output logic      dout
);
  logic s1;
  logic s2;
  logic s3;

  // ----------------------------------------
  // Capture chain; s1 is seen only by s2
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Filter: only a value held by two stages counts
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dout <= 1'b0;
    end else if (s2 == s3) begin
      dout <= s3;
    end
  end
endmodule

// file: hw/rsti_core.sv
// Reset-state registers, tri-state test mode and scan identification path.
// Assumes test pins are asynchronous to ref_clk and the test clock is far slower.
//
// Behaviour
// - The core voltage select output is driven low as soon as reset is sampled.
// - Reset clears the extended feature enable and syscall target registers to zero.
// - After reset general register D holds the signature with the stepping in bits 3:0.
// - Soft initialise leaves the extended feature enable and syscall target registers alone.
// - Tri-state test mode floats every output except the two voltage pins and TDO.
// - In tri-state test mode both voltage pins stay driven low.
// - Sampling reset leaves tri-state test mode and restores normal driving.
// - The test access port keeps working in every mode and TDO is never floated.
// - A 32-bit identification register sits in the scan path under the IDCODE instruction.
// - The identification register holds a 4-bit version in bits 31:28.
// - The identification register holds a 16-bit part number in bits 27:12.
// - The identification register holds an 11-bit maker code in bits 11:1.
// - Bit 0 of the identification register is always one.
// - The dual-voltage detect output is always driven to zero and never floated.
`include "rsti_defs.svh"
module rsti_core
  import rsti_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  input  wire logic                    soft_init,
  input  wire logic                    tristate_req,
  input  wire logic                    msr_wr_extended_feature_enable_reg,
  input  wire logic                    msr_wr_syscall_target_reg,
  input  wire logic [`RSTI_MSR_W-1:0]  msr_wdata,
  input  wire logic                    tck,
  input  wire logic                    tms,
  input  wire logic                    tdi,
  input  wire logic                    trst_n,
  output logic [`RSTI_MSR_W-1:0]       extended_feature_enable_reg,
  output logic [`RSTI_MSR_W-1:0]       syscall_target_reg,
  output logic [`RSTI_GPR_W-1:0]       general_register_d,
  output logic                         tristate_mode,
  output logic                         outputs_oe,
  output logic                         core_voltage_select_out,
  output logic                         core_voltage_select_oe,
  output logic                         dual_voltage_detect_out,
  output logic                         dual_voltage_detect_oe,
  output logic                         tdo,
  output logic                         tdo_oe
);
  logic                    tck_s;
  logic                    tms_s;
  logic                    tdi_s;
  logic                    trst_n_s;
  logic                    tck_d;
  logic                    tck_rise;
  logic                    tck_fall;
  rsti_tap_t               tap;
  rsti_tap_t               next_tap;
  logic [`RSTI_IR_W-1:0]   ir_shift;
  logic [`RSTI_IR_W-1:0]   ir;
  logic [`RSTI_ID_W-1:0]   dr_shift;
  logic                    tdo_next;

  // Identification word assembled from its fields
  function automatic logic [`RSTI_ID_W-1:0] id_word();
    id_word = {`RSTI_VERSION, `RSTI_PART_NUM, `RSTI_MFR_CODE, `RSTI_ID_LSB_VAL};
  endfunction

  // ----------------------------------------
  // Test pin synchronisers
  // ----------------------------------------
  rsti_sync u_sync_tck  (.ref_clk(ref_clk), .reset(reset), .din(tck),    .dout(tck_s));
  rsti_sync u_sync_tms  (.ref_clk(ref_clk), .reset(reset), .din(tms),    .dout(tms_s));
  rsti_sync u_sync_tdi  (.ref_clk(ref_clk), .reset(reset), .din(tdi),    .dout(tdi_s));
  rsti_sync u_sync_trst (.ref_clk(ref_clk), .reset(reset), .din(trst_n), .dout(trst_n_s));

  // Test clock edge finder on the filtered copy
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tck_d <= 1'b0;
    end else begin
      tck_d <= tck_s;
    end
  end
  assign tck_rise = tck_s & ~tck_d;
  assign tck_fall = ~tck_s & tck_d;

  // ----------------------------------------
  // Architectural registers
  // ----------------------------------------
  // Soft initialise deliberately not in this process: contents survive it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      extended_feature_enable_reg <= `RSTI_MSR_RST;
      syscall_target_reg          <= `RSTI_MSR_RST;
    end else begin
      if (msr_wr_extended_feature_enable_reg) begin
        extended_feature_enable_reg <= msr_wdata;
      end
      if (msr_wr_syscall_target_reg) begin
        syscall_target_reg <= msr_wdata;
      end
    end
  end

  // Register D carries the signature after either initialisation
  always_ff @(posedge ref_clk) begin
    if (reset || soft_init) begin
      general_register_d <= {`RSTI_SIG_BASE, `RSTI_STEPPING};
    end
  end

  // ----------------------------------------
  // Tri-state test mode
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tristate_mode <= 1'b0;
    end else if (tristate_req) begin
      tristate_mode <= 1'b1;
    end
  end

  // Ordinary outputs float in test mode and during reset fall back to driven
  assign outputs_oe              = ~tristate_mode;
  assign core_voltage_select_out = 1'b0;
  assign core_voltage_select_oe  = 1'b1;
  assign dual_voltage_detect_out = 1'b0;
  assign dual_voltage_detect_oe  = 1'b1;
  assign tdo_oe                  = 1'b1;

  // ----------------------------------------
  // Test access port controller
  // ----------------------------------------
  always_comb begin
    next_tap = tap;
    unique case (tap)
      RSTI_TLR:    next_tap = tms_s ? RSTI_TLR    : RSTI_RTI;
      RSTI_RTI:    next_tap = tms_s ? RSTI_SEL_DR : RSTI_RTI;
      RSTI_SEL_DR: next_tap = tms_s ? RSTI_SEL_IR : RSTI_CAP_DR;
      RSTI_CAP_DR: next_tap = tms_s ? RSTI_EX1_DR : RSTI_SH_DR;
      RSTI_SH_DR:  next_tap = tms_s ? RSTI_EX1_DR : RSTI_SH_DR;
      RSTI_EX1_DR: next_tap = tms_s ? RSTI_UPD_DR : RSTI_PA_DR;
      RSTI_PA_DR:  next_tap = tms_s ? RSTI_EX2_DR : RSTI_PA_DR;
      RSTI_EX2_DR: next_tap = tms_s ? RSTI_UPD_DR : RSTI_SH_DR;
      RSTI_UPD_DR: next_tap = tms_s ? RSTI_SEL_DR : RSTI_RTI;
      RSTI_SEL_IR: next_tap = tms_s ? RSTI_TLR    : RSTI_CAP_IR;
      RSTI_CAP_IR: next_tap = tms_s ? RSTI_EX1_IR : RSTI_SH_IR;
      RSTI_SH_IR:  next_tap = tms_s ? RSTI_EX1_IR : RSTI_SH_IR;
      RSTI_EX1_IR: next_tap = tms_s ? RSTI_UPD_IR : RSTI_PA_IR;
      RSTI_PA_IR:  next_tap = tms_s ? RSTI_EX2_IR : RSTI_PA_IR;
      RSTI_EX2_IR: next_tap = tms_s ? RSTI_UPD_IR : RSTI_SH_IR;
      RSTI_UPD_IR: next_tap = tms_s ? RSTI_SEL_DR : RSTI_RTI;
    endcase
  end

  // Controller is independent of test mode so the port always works
  always_ff @(posedge ref_clk) begin
    if (reset || !trst_n_s) begin
      tap <= RSTI_TLR;
    end else if (tck_rise) begin
      tap <= next_tap;
    end
  end

  // Instruction register; reset selects IDCODE as the standard asks
  always_ff @(posedge ref_clk) begin
    if (reset || !trst_n_s || (tck_rise && tap == RSTI_TLR)) begin
      ir_shift <= `RSTI_IR_CAPTURE;
      ir       <= `RSTI_IR_IDCODE;
    end else if (tck_rise) begin
      if (tap == RSTI_CAP_IR) begin
        ir_shift <= `RSTI_IR_CAPTURE;
      end else if (tap == RSTI_SH_IR) begin
        ir_shift <= {tdi_s, ir_shift[`RSTI_IR_W-1:1]};
      end else if (tap == RSTI_UPD_IR) begin
        ir <= ir_shift;
      end
    end
  end

  // Data path: identification word under IDCODE, one-bit bypass otherwise
  always_ff @(posedge ref_clk) begin
    if (reset || !trst_n_s) begin
      dr_shift <= '0;
    end else if (tck_rise && tap == RSTI_CAP_DR) begin
      dr_shift <= (ir == `RSTI_IR_IDCODE) ? id_word() : '0;
    end else if (tck_rise && tap == RSTI_SH_DR) begin
      if (ir == `RSTI_IR_IDCODE) begin
        dr_shift <= {tdi_s, dr_shift[`RSTI_ID_W-1:1]};
      end else begin
        dr_shift <= {{(`RSTI_ID_W-1){1'b0}}, tdi_s};
      end
    end
  end

  always_comb begin
    if (tap == RSTI_SH_IR) begin
      tdo_next = ir_shift[0];
    end else if (tap == RSTI_SH_DR) begin
      tdo_next = dr_shift[0];
    end else begin
      tdo_next = 1'b0;
    end
  end

  // TDO changes on the falling test clock edge
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tdo <= 1'b0;
    end else if (tck_fall) begin
      tdo <= tdo_next;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_vsel_low;
    @(posedge ref_clk) reset |-> !core_voltage_select_out && core_voltage_select_oe;
  endproperty
  a_vsel_low: assert property (p_vsel_low) else $error("vsel not low");

  property p_msr_clear;
    @(posedge ref_clk) reset |=> extended_feature_enable_reg == '0 && syscall_target_reg == '0;
  endproperty
  a_msr_clear: assert property (p_msr_clear) else $error("msr not cleared");

  property p_sig;
    @(posedge ref_clk) reset |=> general_register_d == {`RSTI_SIG_BASE, `RSTI_STEPPING};
  endproperty
  a_sig: assert property (p_sig) else $error("signature wrong");

  property p_init_keep;
    @(posedge ref_clk) disable iff (reset)
      soft_init && !msr_wr_extended_feature_enable_reg && !msr_wr_syscall_target_reg |=> $stable(extended_feature_enable_reg)
        && $stable(syscall_target_reg);
  endproperty
  a_init_keep: assert property (p_init_keep) else $error("init changed msr");

  property p_float;
    @(posedge ref_clk) tristate_mode |-> !outputs_oe && tdo_oe && dual_voltage_detect_oe;
  endproperty
  a_float: assert property (p_float) else $error("float set wrong");

  property p_exit;
    @(posedge ref_clk) reset |=> !tristate_mode ##0 outputs_oe;
  endproperty
  a_exit: assert property (p_exit) else $error("mode not left");

  property p_enter;
    @(posedge ref_clk) disable iff (reset) tristate_req |=> tristate_mode [*2];
  endproperty
  a_enter: assert property (p_enter) else $error("mode not entered");

  property p_dvd;
    @(posedge ref_clk) !dual_voltage_detect_out && dual_voltage_detect_oe;
  endproperty
  a_dvd: assert property (p_dvd) else $error("detect not low");

  property p_capture;
    @(posedge ref_clk) disable iff (reset || !trst_n_s)
      tck_rise && tap == RSTI_CAP_DR && ir == `RSTI_IR_IDCODE |=> dr_shift[0] == 1'b1
        && dr_shift[`RSTI_PART_MSB:`RSTI_PART_LSB] == `RSTI_PART_NUM;
  endproperty
  a_capture: assert property (p_capture) else $error("id capture wrong");
endmodule

// file: tb/rsti_scan_host.sv
// Board test equipment model: drives the test pins and reads the id word.
// Assumes the block samples the test pins with ref_clk; tck runs at 80 ns.
module rsti_scan_host (
  input  wire logic ref_clk,
  input  wire logic tdo,
  input  wire logic tdo_oe,
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trst_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // -------------------------------------------------
  // Test clock stands still low between frames
  // -------------------------------------------------
  initial begin
    tck    = 1'b0;
    tms    = 1'b1;
    tdi    = 1'b0;
    trst_n = 1'b1;
  end

  // One test clock period; tdo is taken late in the high phase, well after
  // the block moved it on the previous fall, since its path is synchronised
  task automatic pulse(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    tck <= 1'b1;
    repeat (4) @(posedge ref_clk);
    q = (tdo_oe === 1'b1) ? tdo : 1'bx;
    @(posedge ref_clk);
    tck <= 1'b0;
    tdi <= ~d;
    repeat (5) @(posedge ref_clk);
  endtask

  // Five high tms bits reach test-logic-reset, one low bit parks in idle
  task automatic tap_reset();
    logic q;
    for (int i = 0; i < 5; i++) pulse(1'b1, 1'b0, q);
    pulse(1'b0, 1'b0, q);
  endtask

  // From idle: scan n bits through the instruction or data path, first bit
  // lowest, and return to idle; the instruction takes effect on that return
  task automatic scan(input logic ir_path, input int n, input logic [31:0] din,
                      output logic [31:0] v);
    logic q;
    v = '0;
    pulse(1'b1, 1'b0, q);
    if (ir_path) pulse(1'b1, 1'b0, q);
    pulse(1'b0, 1'b0, q);
    pulse(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      pulse(i == n - 1, din[i], q);
      v[i] = q;
    end
    pulse(1'b1, 1'b0, q);
    pulse(1'b0, 1'b0, q);
  endtask

  // Port reset pin held well past the synchroniser depth, then step to idle
  task automatic port_reset();
    logic q;
    trst_n <= 1'b0;
    repeat (10) @(posedge ref_clk);
    trst_n <= 1'b1;
    repeat (10) @(posedge ref_clk);
    pulse(1'b0, 1'b0, q);
  endtask

  // Reset the port, walk to data shift and take 32 bits, first bit lowest
  task automatic read_id(output logic [31:0] v);
    tap_reset();
    scan(1'b0, 32, 32'h0, v);
  endtask
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the reset-state and test identification block.
// Assumes the scan host model owns the test pins; ref_clk runs at 125 MHz.
`include "rsti_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk, reset, soft_init, tristate_req, msr_wr_extended_feature_enable_reg, msr_wr_syscall_target_reg;
  logic [63:0] msr_wdata, extended_feature_enable_reg, syscall_target_reg;
  logic [31:0] general_register_d, id;
  logic        tck, tms, tdi, trst_n, tristate_mode, outputs_oe, tdo, tdo_oe;
  logic        core_voltage_select_out, core_voltage_select_oe;
  logic        dual_voltage_detect_out, dual_voltage_detect_oe;
  int          n_mismatch, comparisons;
  localparam logic [31:0] SIG = {`RSTI_SIG_BASE, `RSTI_STEPPING};

  rsti_core rsti_core_i (.ref_clk, .reset, .soft_init, .tristate_req, .msr_wr_extended_feature_enable_reg,
    .msr_wr_syscall_target_reg, .msr_wdata, .tck, .tms, .tdi, .trst_n, .extended_feature_enable_reg,
    .syscall_target_reg, .general_register_d, .tristate_mode, .outputs_oe,
    .core_voltage_select_out, .core_voltage_select_oe, .dual_voltage_detect_out,
    .dual_voltage_detect_oe, .tdo, .tdo_oe);
  rsti_scan_host rsti_scan_host_i (.ref_clk, .tdo, .tdo_oe, .tck, .tms, .tdi, .trst_n);

  // -------------------------------------------------
  // Clock, shared tasks and verdict
  // -------------------------------------------------
  always #4 ref_clk = ~ref_clk;

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Strobe held one edge, then dropped for one edge before the next call
  task automatic wr_msr(input logic to_syscall_target_reg, input logic [63:0] d);
    msr_wr_extended_feature_enable_reg <= ~to_syscall_target_reg;
    msr_wr_syscall_target_reg <= to_syscall_target_reg;
    msr_wdata   <= d;
    step(1);
    msr_wr_extended_feature_enable_reg <= 1'b0;
    msr_wr_syscall_target_reg <= 1'b0;
    step(1);
  endtask

  // Voltage pins low and driven, tdo driven, in every mode
  task automatic check_pins();
    check("cvs out", 64'h0, core_voltage_select_out);
    check("cvs oe", 64'h1, core_voltage_select_oe);
    check("dvd out", 64'h0, dual_voltage_detect_out);
    check("dvd oe", 64'h1, dual_voltage_detect_oe);
    check("tdo oe", 64'h1, tdo_oe);
  endtask

  task automatic check_reset_state();
    check("extended_feature_enable_reg", 64'h0, extended_feature_enable_reg);
    check("syscall_target_reg", 64'h0, syscall_target_reg);
    check("gpr d", {32'h0, SIG}, general_register_d);
    check("mode", 64'h0, tristate_mode);
    check("out oe", 64'h1, outputs_oe);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Hang guard well above the longest sequence
  initial begin
    repeat (100000) @(posedge ref_clk);
    n_mismatch++;
    print_verdict();
  end

  // -------------------------------------------------
  // Main sequence
  // -------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    reset = 1'b1;
    soft_init = 1'b0;
    tristate_req = 1'b0;
    msr_wr_extended_feature_enable_reg = 1'b0;
    msr_wr_syscall_target_reg = 1'b0;
    msr_wdata = 64'h0;
    step(1);
    check("cvs in reset", 64'h0, core_voltage_select_out);
    step(11);
    reset <= 1'b0;
    step(4);
    check_reset_state();
    check_pins();
    // Two writes one idle edge apart, then soft initialise must leave them alone
    wr_msr(1'b0, 64'h1);
    wr_msr(1'b1, 64'hfedc_ba98_7654_3210);
    soft_init <= 1'b1;
    step(1);
    soft_init <= 1'b0;
    step(2);
    check("extended_feature_enable_reg kept", 64'h1, extended_feature_enable_reg);
    check("syscall_target_reg kept", 64'hfedc_ba98_7654_3210, syscall_target_reg);
    check("gpr d init", {32'h0, SIG}, general_register_d);
    // Tri-state test mode: outputs float, voltage pins and scan stay alive
    tristate_req <= 1'b1;
    step(1);
    tristate_req <= 1'b0;
    step(1);
    check("mode", 64'h1, tristate_mode);
    check("out oe", 64'h0, outputs_oe);
    check_pins();
    rsti_scan_host_i.read_id(id);
    check("id word", {32'h0, `RSTI_VERSION, `RSTI_PART_NUM, `RSTI_MFR_CODE, 1'b1}, id);
    check("id version", 64'(`RSTI_VERSION), id[31:28]);
    check("id part", 64'(`RSTI_PART_NUM), id[27:12]);
    check("id maker", 64'(`RSTI_MFR_CODE), id[11:1]);
    check("id lsb", 64'h1, id[0]);
    // Instruction capture pattern, bypass path, then port reset restores the id word
    rsti_scan_host_i.scan(1'b1, 4, 32'(`RSTI_IR_BYPASS), id);
    check("ir capture", 64'(`RSTI_IR_CAPTURE), id);
    rsti_scan_host_i.scan(1'b0, 32, 32'h1234_5679, id);
    check("bypass", 64'h2468_acf2, id);
    rsti_scan_host_i.port_reset();
    rsti_scan_host_i.scan(1'b0, 32, 32'h0, id);
    check("id after port reset", {32'h0, `RSTI_VERSION, `RSTI_PART_NUM, `RSTI_MFR_CODE, 1'b1}, id);
    // Second reset with a write attempt inside it: mode left, registers cleared
    reset <= 1'b1;
    step(1);
    wr_msr(1'b1, 64'h5555_aaaa_5555_aaaa);
    check("cvs in reset", 64'h0, core_voltage_select_out);
    reset <= 1'b0;
    step(4);
    check_reset_state();
    rsti_scan_host_i.read_id(id);
    check("id lsb again", 64'h1, id[0]);
    print_verdict();
  end
endmodule
